// File: itm_pkg.sv
package itm_pkg;
  // register byte offsets
  localparam logic [7:0] ITM_OFF_COUNT    = 8'h00;
  localparam logic [7:0] ITM_OFF_PRESCALE = 8'h04;
  localparam logic [7:0] ITM_OFF_PERIOD   = 8'h08;
  localparam logic [7:0] ITM_OFF_CTRL     = 8'h0C;
  localparam logic [7:0] ITM_OFF_STATUS   = 8'h10;
  localparam logic [7:0] ITM_OFF_MASK     = 8'h14;
  // widths
  localparam int ITM_CNT_W = 16;
  localparam int ITM_SCL_W = 8;
  // reset values
  localparam logic [15:0] ITM_COUNT_RST    = 16'h0000;
  localparam logic [7:0]  ITM_PRESCALE_RST = 8'h00;
  localparam logic [15:0] ITM_PERIOD_RST   = 16'h0000;
  localparam logic        ITM_ENABLE_RST   = 1'b0;
  localparam logic        ITM_MASK_RST     = 1'b0;
  // field positions
  localparam int ITM_CTRL_EN_BIT   = 0;
  localparam int ITM_STAT_ZERO_BIT = 0;
  // ahb encodings
  localparam logic [1:0] ITM_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] ITM_HTRANS_SEQ    = 2'b11;
endpackage

// File: itm_interval_timer.sv
// What this block does
// - a 16-bit down-counter decrements once every n clock cycles
// - an 8-bit prescale register stores n minus one
// - count reaching zero raises the timer interrupt request
// - at zero the count reloads from the 16-bit period register
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module itm_interval_timer
  import itm_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt
  output logic             timer_irq
);
  import itm_pkg::*;

  logic [ITM_CNT_W-1:0] timer_count;
  logic [ITM_SCL_W-1:0] timer_prescale;
  logic [ITM_CNT_W-1:0] timer_period;
  logic [ITM_SCL_W-1:0] scale_cnt;
  logic                 enable;
  logic                 status;
  logic                 mask;
  logic                 dp_write;
  logic [7:0]           dp_addr;
  logic                 tick;
  logic                 zero_event;
  logic                 wr_count;
  logic                 wr_prescale;
  logic                 wr_period;
  logic                 wr_ctrl;
  logic                 wr_status;
  logic                 wr_mask;
  logic                 status_clear;
  logic                 ap_valid;
  logic                 ap_read;
  logic                 ap_write;
  logic [7:0]           ap_addr;
  logic [31:0]          next_hrdata;
  logic [ITM_SCL_W-1:0] next_scale_cnt;
  logic [ITM_CNT_W-1:0] next_timer_count;
  logic                 count_at_zero;
  logic                 count_at_one;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase qualification
  assign ap_valid = hready && hsel && (htrans == ITM_HTRANS_NONSEQ || htrans == ITM_HTRANS_SEQ);
  assign ap_read  = ap_valid && !hwrite;
  assign ap_write = ap_valid && hwrite;
  assign ap_addr  = haddr[7:0];

  // data phase write flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
    end else if (hready) begin
      dp_write <= ap_write;
    end else begin
      dp_write <= 1'b0;
    end
  end

  // data phase address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_addr <= ap_addr;
    end
  end

  // read data selection
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (addr_is(ap_addr, ITM_OFF_COUNT)) begin
      next_hrdata = {16'h0000, timer_count};
    end else if (addr_is(ap_addr, ITM_OFF_PRESCALE)) begin
      next_hrdata = {24'h00_0000, timer_prescale};
    end else if (addr_is(ap_addr, ITM_OFF_PERIOD)) begin
      next_hrdata = {16'h0000, timer_period};
    end else if (addr_is(ap_addr, ITM_OFF_CTRL)) begin
      next_hrdata = {31'h0000_0000, enable};
    end else if (addr_is(ap_addr, ITM_OFF_STATUS)) begin
      next_hrdata = {31'h0000_0000, status};
    end else if (addr_is(ap_addr, ITM_OFF_MASK)) begin
      next_hrdata = {31'h0000_0000, mask};
    end else begin
      next_hrdata = 32'h0000_0000;
    end
  end

  // read data registered at address phase, held through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_read) begin
      hrdata <= next_hrdata;
    end
  end

  // data phase write decode
  assign wr_count     = dp_write && addr_is(dp_addr, ITM_OFF_COUNT);
  assign wr_prescale  = dp_write && addr_is(dp_addr, ITM_OFF_PRESCALE);
  assign wr_period    = dp_write && addr_is(dp_addr, ITM_OFF_PERIOD);
  assign wr_ctrl      = dp_write && addr_is(dp_addr, ITM_OFF_CTRL);
  assign wr_status    = dp_write && addr_is(dp_addr, ITM_OFF_STATUS);
  assign wr_mask      = dp_write && addr_is(dp_addr, ITM_OFF_MASK);
  assign status_clear = wr_status && hwdata[ITM_STAT_ZERO_BIT];

  // scale setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_prescale <= ITM_PRESCALE_RST;
    end else if (wr_prescale) begin
      timer_prescale <= hwdata[ITM_SCL_W-1:0];
    end
  end

  // period setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_period <= ITM_PERIOD_RST;
    end else if (wr_period) begin
      timer_period <= hwdata[ITM_CNT_W-1:0];
    end
  end

  // run enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable <= ITM_ENABLE_RST;
    end else if (wr_ctrl) begin
      enable <= hwdata[ITM_CTRL_EN_BIT];
    end
  end

  // interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= ITM_MASK_RST;
    end else if (wr_mask) begin
      mask <= hwdata[ITM_STAT_ZERO_BIT];
    end
  end

  // prescaler
  assign tick = enable && (scale_cnt == 8'h00);

  always_comb begin
    next_scale_cnt = scale_cnt;
    if (wr_prescale) begin
      next_scale_cnt = hwdata[ITM_SCL_W-1:0];
    end else if (tick) begin
      next_scale_cnt = timer_prescale;
    end else if (enable) begin
      next_scale_cnt = scale_cnt - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scale_cnt <= ITM_PRESCALE_RST;
    end else begin
      scale_cnt <= next_scale_cnt;
    end
  end

  // main counter
  assign count_at_zero = (timer_count == 16'h0000);
  assign count_at_one  = (timer_count == 16'h0001);
  // a count write in the same cycle overrides the step to zero
  assign zero_event    = tick && !wr_count && count_at_one;

  always_comb begin
    next_timer_count = timer_count;
    if (wr_count) begin
      next_timer_count = hwdata[ITM_CNT_W-1:0];
    end else if (tick && count_at_zero) begin
      next_timer_count = timer_period;
    end else if (tick) begin
      next_timer_count = timer_count - 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count <= ITM_COUNT_RST;
    end else begin
      timer_count <= next_timer_count;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= 1'b0;
    end else if (zero_event) begin
      status <= 1'b1;
    end else if (status_clear) begin
      status <= 1'b0;
    end
  end


  assign timer_irq = status && mask;
endmodule

// File: itm_interval_timer_props.sv
`timescale 1ns/1ps
module itm_props
  import itm_pkg::*;
(
  // bus and interrupt
  input wire logic        hclk, hresetn, hsel, hwrite, hready, timer_irq,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata
);
  logic       wq, rq, en;
  logic [7:0] aq;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wq, rq, en, aq} <= '0;
    end else begin
      wq <= hsel & hready & htrans[1] & hwrite;
      rq <= hsel & hready & htrans[1] & !hwrite;
      aq <= haddr[7:0];
      if (wq && aq == ITM_OFF_CTRL) en <= hwdata[ITM_CTRL_EN_BIT];
    end
  end
  property p_sticky; $fell(timer_irq) |-> $past(wq); endproperty
  a_sticky: assert property (p_sticky) else $error("irq fell with no write");
  property p_rise; $rose(timer_irq) |-> $past(en) || $past(wq); endproperty
  a_rise: assert property (p_rise) else $error("irq rose while stopped");
  property p_scl; rq && aq == ITM_OFF_PRESCALE |-> hrdata[31:8] == 24'h0; endproperty
  a_scl: assert property (p_scl) else $error("prescale too wide");
  property p_cnt; rq && aq == ITM_OFF_COUNT |-> hrdata[31:16] == 16'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("count too wide");
  property p_per; rq && aq == ITM_OFF_PERIOD |-> hrdata[31:16] == 16'h0; endproperty
  a_per: assert property (p_per) else $error("period too wide");
endmodule
bind itm_interval_timer itm_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .timer_irq(timer_irq), .htrans(htrans),
  .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata));

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import itm_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rv = 0;
  logic        hreadyout, hresp, timer_irq;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, got, exp_q[$], gap_q[$];
  int          failures = 0, total_checks = 0, seed = 99066, cyc = 0, last, p, n;
  itm_interval_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_irq(timer_irq));
  always #12.5 hclk = ~hclk;
  task automatic chk(input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, ITM_HTRANS_NONSEQ, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {3'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    got = hrdata;
    rv <= !w;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, a, 0);
  endtask
  // result watcher
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (rv) begin
      rv <= 0;
      chk(exp_q.pop_front(), got);
      chk(32'h0000_0000, {31'h0000_0000, hresp});
    end
    if ($rose(timer_irq) && last != 0 && gap_q.size() != 0) chk(gap_q.pop_front(), cyc - last);
    if ($rose(timer_irq)) last = cyc;
  end
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 0);
    bus(1, ITM_OFF_PRESCALE, 32'hFFFF_FFFF);
    rd(ITM_OFF_PRESCALE, 32'h0000_00FF);
    bus(1, ITM_OFF_PERIOD, 32'hFFFF_FFFF);
    rd(ITM_OFF_PERIOD, 32'h0000_FFFF);
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 0 : $random(seed) & 7;
      n = 4 + ($random(seed) & 7);
      last = 0;
      repeat (2) gap_q.push_back((n + 1) * (p + 1));
      bus(1, ITM_OFF_MASK, 1);
      bus(1, ITM_OFF_PRESCALE, p);
      bus(1, ITM_OFF_PERIOD, n);
      bus(1, ITM_OFF_COUNT, n);
      bus(1, ITM_OFF_CTRL, 1);
      repeat (3) begin
        #1 wait (timer_irq === 1'b1);
        bus(1, ITM_OFF_STATUS, 1);
      end
      bus(1, ITM_OFF_CTRL, 0);
      bus(1, ITM_OFF_STATUS, 1);
    end
    bus(1, ITM_OFF_MASK, 0);
    bus(1, ITM_OFF_CTRL, 1);
    repeat (100) @(posedge hclk);
    chk(32'h0000_0000, {31'h0000_0000, timer_irq});
    rd(ITM_OFF_STATUS, 1);
    conclude();
  end
endmodule
